// ===== sdram_ctrl_end.sv
// Controller end: register-driven command issue onto the DRAM pins
`timescale 1ns/1ps
module sdram_ctrl_end
   import sdram_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   sdram_link_if.ctrl link,
   input wire logic [1:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData
);
`include "sdram_link_consts.svh"

   ctrl_state_s st;
   ctrl_state_s next_st;
   cmd_e req;
   logic issue;
   logic modeOk;
   logic [2:0] lenCode;
   logic [2:0] latCode;

   // ---------------------------------------------------------------
   // Command issue
   // ---------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      req = cmd_e'(regWrData[3:0]);
      lenCode = st.addrReg[`MR_LEN_MSB:`MR_LEN_LSB];
      latCode = st.addrReg[`MR_LAT_MSB:`MR_LAT_LSB];
      // Speed-grade limits on latency belong to the clock choice of the system
      modeOk = (latCode == `LAT_TWO || latCode == `LAT_THREE)
             && (lenCode <= `LEN_EIGHT || (lenCode == `LEN_PAGE && !st.addrReg[`MR_ORDER_BIT]));
      issue = regWrite && regAddr == `REG_COMMAND && req != CMD_INHIBIT;
      next_st.csN = 1'b1;
      next_st.rasN = 1'b1;
      next_st.casN = 1'b1;
      next_st.weN = 1'b1;
      next_st.cke = 1'b1;
      next_st.dqm = st.wrMask;
      next_st.dqOut = st.wrData;
      next_st.regRdData = 32'h0000_0000;
      if (st.waitCount != 4'h0)
      begin
         next_st.waitCount = st.waitCount - 4'h1;
      end
      if (regWrite && regAddr == `REG_ADDRESS)
      begin
         next_st.addrReg = regWrData[12:0];
         next_st.bankReg = regWrData[14:13];
      end
      if (regWrite && regAddr == `REG_WRITE_DATA)
      begin
         next_st.wrData = regWrData[15:0];
         next_st.wrMask = regWrData[17:16];
      end
      if (issue)
      begin
         // Any order is refused while the mode register settles
         if (st.waitCount != 4'h0 || (req == CMD_LOAD_MODE && (st.banksOpen != 4'h0 || !modeOk)))
         begin
            next_st.refused = 1'b1;
         end
         else
         begin
            next_st.csN = 1'b0;
            next_st.ba = st.bankReg;
            next_st.addr = st.addrReg;
            next_st.dqOe = 1'b0;
            case (req)
               CMD_NOP: ;
               CMD_ACTIVE:
               begin
                  next_st.rasN = 1'b0;
                  next_st.banksOpen[st.bankReg] = 1'b1;
               end
               CMD_READ:
               begin
                  next_st.casN = 1'b0;
                  if (st.addrReg[`PRECHARGE_SELECT_LINE])
                  begin
                     next_st.banksOpen[st.bankReg] = 1'b0;
                  end
               end
               CMD_WRITE:
               begin
                  next_st.casN = 1'b0;
                  next_st.weN = 1'b0;
                  next_st.dqOe = 1'b1;
                  if (st.addrReg[`PRECHARGE_SELECT_LINE])
                  begin
                     next_st.banksOpen[st.bankReg] = 1'b0;
                  end
               end
               CMD_TERMINATE: next_st.weN = 1'b0;
               CMD_PRECHARGE:
               begin
                  next_st.rasN = 1'b0;
                  next_st.weN = 1'b0;
                  if (st.addrReg[`PRECHARGE_SELECT_LINE])
                  begin
                     next_st.banksOpen = 4'h0;
                  end
                  else
                  begin
                     next_st.banksOpen[st.bankReg] = 1'b0;
                  end
               end
               CMD_REFRESH:
               begin
                  next_st.rasN = 1'b0;
                  next_st.casN = 1'b0;
               end
               CMD_SELF_REFRESH:
               begin
                  next_st.rasN = 1'b0;
                  next_st.casN = 1'b0;
                  next_st.cke = 1'b0;
               end
               CMD_LOAD_MODE:
               begin
                  next_st.rasN = 1'b0;
                  next_st.casN = 1'b0;
                  next_st.weN = 1'b0;
                  next_st.addr = {1'b0, st.addrReg[11:9], 2'b00, st.addrReg[6:0]};
                  next_st.waitCount = `MODE_WAIT_CYCLES;
               end
               default: next_st.csN = 1'b1;
            endcase
         end
      end
      // Captured read word; a capture beats a clearing read
      if (regRead && regAddr == `REG_READ_DATA)
      begin
         next_st.regRdData = {15'h0000, st.rdFresh, st.rdData};
         next_st.rdFresh = 1'b0;
      end
      if (regRead && regAddr == `REG_COMMAND)
      begin
         next_st.regRdData = {26'h000_0000, st.waitCount != 4'h0, st.refused, st.banksOpen};
         next_st.refused = 1'b0;
      end
      if (regRead && regAddr == `REG_ADDRESS)
      begin
         next_st.regRdData = {17'h0_0000, st.bankReg, st.addrReg};
      end
      if (regRead && regAddr == `REG_WRITE_DATA)
      begin
         next_st.regRdData = {14'h0000, st.wrMask, st.wrData};
      end
      if (issue && next_st.csN && req != CMD_INHIBIT && !(req == CMD_NOP))
      begin
         next_st.refused = 1'b1;
      end
      if (link.dqMemOe != 2'b00)
      begin
         next_st.rdData = link.dqLevel;
         next_st.rdFresh = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.csN <= 1'b1;
         st.rasN <= 1'b1;
         st.casN <= 1'b1;
         st.weN <= 1'b1;
         st.cke <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign link.csN = st.csN;
   assign link.rasN = st.rasN;
   assign link.casN = st.casN;
   assign link.weN = st.weN;
   assign link.cke = st.cke;
   assign link.ba = st.ba;
   assign link.addr = st.addr;
   assign link.dqm = st.dqm;
   assign link.dqCtrl = st.dqOut;
   assign link.dqCtrlOe = st.dqOe;
   assign regRdData = st.regRdData;
endmodule

// ===== sdram_link_consts.svh
// Constants shared by both ends of the synchronous DRAM command link
`ifndef SDRAM_LINK_CONSTS_SVH
`define SDRAM_LINK_CONSTS_SVH

// ---------------------------------------------------------------
// Mode configuration field layout
// ---------------------------------------------------------------
`define MR_LEN_LSB 0
`define MR_LEN_MSB 2
`define MR_ORDER_BIT 3
`define MR_LAT_LSB 4
`define MR_LAT_MSB 6
`define MR_OP_LOW_BIT 7
`define MR_OP_HIGH_BIT 8
`define MR_SINGLE_WRITE_BIT 9
`define MR_RESET 12'h000

// ---------------------------------------------------------------
// Field codes
// ---------------------------------------------------------------
`define LEN_ONE 3'h0
`define LEN_TWO 3'h1
`define LEN_FOUR 3'h2
`define LEN_EIGHT 3'h3
`define LEN_PAGE 3'h7
`define LAT_TWO 3'h2
`define LAT_THREE 3'h3
`define PAGE_MASK 10'h3ff
`define PRECHARGE_SELECT_LINE 10

// ---------------------------------------------------------------
// Controller register offsets and timing
// ---------------------------------------------------------------
`define REG_ADDRESS 2'h0
`define REG_WRITE_DATA 2'h1
`define REG_COMMAND 2'h2
`define REG_READ_DATA 2'h3
`define MODE_WAIT_CYCLES 4'h2

`endif

// ===== sdram_link_if.sv
// Pin bundle between the DRAM controller end and the DRAM device end
`timescale 1ns/1ps
interface sdram_link_if (
   input wire logic ref_clk
);
   logic csN;
   logic rasN;
   logic casN;
   logic weN;
   logic cke;
   logic [1:0] ba;
   logic [12:0] addr;
   logic [1:0] dqm;
   logic [15:0] dqCtrl;
   logic dqCtrlOe;
   logic [15:0] dqMem;
   logic [1:0] dqMemOe;
   logic [15:0] dqLevel;

   // Device drive wins per byte; an undriven byte reads as zero
   assign dqLevel = (dqMem & {{8{dqMemOe[1]}}, {8{dqMemOe[0]}}})
                  | (dqCtrl & {16{dqCtrlOe}} & {{8{~dqMemOe[1]}}, {8{~dqMemOe[0]}}});

   modport ctrl (
      input ref_clk,
      output csN, rasN, casN, weN, cke, ba, addr, dqm, dqCtrl, dqCtrlOe,
      input dqMem, dqMemOe, dqLevel
   );

   modport mem (
      input ref_clk,
      input csN, rasN, casN, weN, cke, ba, addr, dqm, dqCtrl, dqCtrlOe,
      output dqMem, dqMemOe,
      input dqLevel
   );
endinterface

// ===== sdram_link_pkg.sv
// Types shared by both ends of the synchronous DRAM command link
package sdram_link_pkg;

   typedef enum logic [3:0] {
      CMD_INHIBIT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
      CMD_TERMINATE, CMD_PRECHARGE, CMD_REFRESH, CMD_SELF_REFRESH, CMD_LOAD_MODE
   } cmd_e;

   typedef struct packed {
      logic [11:0] mode;
      logic [3:0] bankOpen;
      logic [3:0][12:0] openRow;
      logic active;
      logic isWrite;
      logic autoPre;
      logic [1:0] burstBank;
      logic [9:0] startCol;
      logic [9:0] mask;
      logic seq;
      logic [9:0] beat;
      logic accValid;
      logic accWrite;
      logic [1:0] accBank;
      logic [12:0] accRow;
      logic [9:0] accCol;
      logic [15:0] accData;
      logic [1:0] accMask;
      logic [15:0] rdPipe;
      logic rdPipeVal;
      logic [1:0] dqmD1;
      logic [15:0] dqOut;
      logic [1:0] dqOe;
      logic refreshPulse;
      logic selfRefresh;
      logic autoPrePulse;
   } mem_state_s;

   typedef struct packed {
      logic [12:0] addrReg;
      logic [1:0] bankReg;
      logic [15:0] wrData;
      logic [1:0] wrMask;
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic cke;
      logic [1:0] ba;
      logic [12:0] addr;
      logic [1:0] dqm;
      logic [15:0] dqOut;
      logic dqOe;
      logic [3:0] banksOpen;
      logic [3:0] waitCount;
      logic [15:0] rdData;
      logic rdFresh;
      logic refused;
      logic [31:0] regRdData;
   } ctrl_state_s;

endpackage

// ===== sdram_link_sva.sv
// Link-level assertions between the controller end and the device end
`timescale 1ns/1ps
module sdram_link_sva (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic cke,
   input wire logic [12:0] addr,
   input wire logic [1:0] dqm,
   input wire logic dqCtrlOe,
   input wire logic [1:0] dqMemOe
);
   logic [11:0] mode;
   logic [3:0] idle;
   logic rdCmd;
   logic wrCmd;
   logic ldCmd;
   assign rdCmd = !csN && rasN && !casN && weN;
   assign wrCmd = !csN && rasN && !casN && !weN;
   assign ldCmd = !csN && !rasN && !casN && !weN;

   // Shadow of the loaded mode so latency checks know the setting
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode <= 12'h000;
         idle <= 4'h0;
      end
      else
      begin
         if (ldCmd)
         begin
            mode <= addr[11:0];
         end
         idle <= rdCmd ? 4'h0 : (idle == 4'hf ? idle : idle + 4'h1);
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_load_top_low: assert property (ldCmd |-> addr[12] == 1'b0 && addr[8:7] == 2'b00)
      else $error("load mode with top or operating bits set");
   a_load_legal: assert property (ldCmd |-> addr[6:4] inside {3'h2, 3'h3} && !(addr[2:0] inside {3'h4, 3'h5, 3'h6})
      && !(addr[2:0] == 3'h7 && addr[3]))
      else $error("reserved mode code loaded");
   a_cke_only_sr: assert property (!cke |-> !csN && !rasN && !casN && weN)
      else $error("clock enable low outside self refresh entry");
   a_cke_short: assert property ($fell(cke) |=> cke)
      else $error("clock enable held low past entry");
   a_wr_drives: assert property (wrCmd |-> dqCtrlOe)
      else $error("write data not driven with write command");
   a_rd_release: assert property (rdCmd |=> !dqCtrlOe)
      else $error("controller drives bus during read");
   a_lat_two: assert property (rdCmd && dqm == 2'b00 && mode[6:4] != 3'h3 |-> ##1 dqMemOe == 2'b00 ##1 dqMemOe == 2'b11)
      else $error("latency two read drive timing wrong");
   a_lat_three: assert property (rdCmd && dqm == 2'b00 && mode[6:4] == 3'h3 |-> ##2 dqMemOe == 2'b00 ##1 dqMemOe == 2'b11)
      else $error("latency three read drive timing wrong");
   a_rd_masked: assert property (rdCmd && dqm == 2'b11 |-> ##2 dqMemOe == 2'b00 ##1 dqMemOe == 2'b00)
      else $error("masked read drove the bus");
   a_bus_quiet: assert property (idle == 4'hf |-> dqMemOe == 2'b00)
      else $error("device drives bus long after last read");
   a_load_wait: assert property (ldCmd |=> csN [*2])
      else $error("command too soon after mode load");
endmodule

// ===== sdram_mem_end.sv
// Device end: command decode, mode register and burst column sequencing
//
// What this block does
// - Burst one/two/four/eight both orders; page sequential only
// - Page burst covers 1024 columns, wraps in row
// - Upper column bits pick aligned block; wrap inside
// - Sequential adds beat; interleaved XORs beat
// - Order bit and low length field steer bursts
// - Length one hits exact column, order ignored
// - Read latency two or three clocks
// - Controller accepts only latency two or three
// - Controller loads only normal, legal mode codes
// - Single write select makes writes one location
// - Strobe combinations decode into eight commands
// - Chip select high ignores command inputs
// - Read/write take column, bank, per-command auto precharge
// - Precharge closes one bank or all four
// - Activate opens addressed row in chosen bank
// - Load mode stores twelve low address bits
// - Byte masks: writes immediate, reads two clocks late
// - Refresh code: auto with clock enable, else self
// - Controller keeps clock enable high except self refresh
// - Terminate cuts the latest read or write burst
// - Controller loads mode only when idle, then waits
`timescale 1ns/1ps
module sdram_mem_end
   import sdram_link_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   sdram_link_if.mem link,
   input wire logic [15:0] readData,
   output logic accValid,
   output logic accWrite,
   output logic [1:0] accBank,
   output logic [12:0] accRow,
   output logic [9:0] accCol,
   output logic [15:0] accData,
   output logic [1:0] accMask,
   output logic [3:0] bankOpen,
   output logic [11:0] modeConfig,
   output logic refreshPulse,
   output logic selfRefresh,
   output logic autoPrePulse
);
`include "sdram_link_consts.svh"

   mem_state_s st;
   mem_state_s next_st;
   cmd_e cmd;
   logic [9:0] stepMask;
   logic stepSeq;
   logic [9:0] nextBeat;
   logic latThree;
   logic rdBeat;

   // ---------------------------------------------------------------
   // Column within the burst block
   // ---------------------------------------------------------------
   function automatic logic [9:0] burst_col(input logic [9:0] start, input logic [9:0] mask,
                                             input logic seq, input logic [9:0] beat);
      logic [9:0] off;
      off = seq ? 10'(start + beat) : (start ^ beat);
      return (start & ~mask) | (off & mask);
   endfunction

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   always_comb
   begin
      cmd = CMD_INHIBIT;
      if (!link.csN)
      begin
         case ({link.rasN, link.casN, link.weN})
            3'b111: cmd = CMD_NOP;
            3'b011: cmd = CMD_ACTIVE;
            3'b101: cmd = CMD_READ;
            3'b100: cmd = CMD_WRITE;
            3'b110: cmd = CMD_TERMINATE;
            3'b010: cmd = CMD_PRECHARGE;
            3'b001: cmd = link.cke ? CMD_REFRESH : CMD_SELF_REFRESH;
            3'b000: cmd = CMD_LOAD_MODE;
            default: cmd = CMD_NOP;
         endcase
         // Power-down is outside this block: a held-low enable drops other orders
         if (!link.cke && cmd != CMD_SELF_REFRESH)
         begin
            cmd = CMD_INHIBIT;
         end
      end
   end

   // ---------------------------------------------------------------
   // Burst shape from the mode configuration
   // ---------------------------------------------------------------
   always_comb
   begin
      stepSeq = !st.mode[`MR_ORDER_BIT];
      case (st.mode[`MR_LEN_MSB:`MR_LEN_LSB])
         `LEN_ONE: stepMask = 10'h000;
         `LEN_TWO: stepMask = 10'h001;
         `LEN_FOUR: stepMask = 10'h003;
         `LEN_EIGHT: stepMask = 10'h007;
         `LEN_PAGE:
         begin
            stepMask = `PAGE_MASK;
            stepSeq = 1'b1;
         end
         default: stepMask = 10'h000;
      endcase
      latThree = st.mode[`MR_LAT_MSB:`MR_LAT_LSB] == `LAT_THREE;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      nextBeat = 10'(st.beat + 10'h001);
      rdBeat = st.accValid && !st.accWrite;
      next_st.accValid = 1'b0;
      next_st.refreshPulse = 1'b0;
      next_st.autoPrePulse = 1'b0;
      next_st.dqmD1 = link.dqm;
      // Read data pipe: the memory array answers in the beat cycle
      next_st.rdPipe = readData;
      next_st.rdPipeVal = rdBeat;
      next_st.dqOut = latThree ? st.rdPipe : readData;
      next_st.dqOe = {2{latThree ? st.rdPipeVal : rdBeat}} & ~st.dqmD1;
      if (link.cke)
      begin
         next_st.selfRefresh = 1'b0;
      end
      // Continue the running burst
      if (st.active)
      begin
         next_st.accValid = 1'b1;
         next_st.accWrite = st.isWrite;
         next_st.accCol = burst_col(st.startCol, st.mask, st.seq, st.beat);
         next_st.accData = link.dqLevel;
         next_st.accMask = link.dqm;
         next_st.beat = nextBeat;
         if (st.beat == st.mask && st.mask != `PAGE_MASK)
         begin
            next_st.active = 1'b0;
            if (st.autoPre)
            begin
               next_st.bankOpen[st.burstBank] = 1'b0;
               next_st.autoPrePulse = 1'b1;
            end
         end
      end
      case (cmd)
         CMD_ACTIVE:
         begin
            next_st.bankOpen[link.ba] = 1'b1;
            next_st.openRow[link.ba] = link.addr;
         end
         CMD_READ, CMD_WRITE:
         begin
            next_st.isWrite = cmd == CMD_WRITE;
            next_st.mask = (cmd == CMD_WRITE && st.mode[`MR_SINGLE_WRITE_BIT]) ? 10'h000 : stepMask;
            next_st.seq = stepSeq;
            next_st.startCol = link.addr[9:0];
            next_st.burstBank = link.ba;
            // Page bursts never precharge on their own
            next_st.autoPre = link.addr[`PRECHARGE_SELECT_LINE] && next_st.mask != `PAGE_MASK;
            next_st.accValid = 1'b1;
            next_st.accWrite = cmd == CMD_WRITE;
            next_st.accBank = link.ba;
            next_st.accRow = st.openRow[link.ba];
            next_st.accCol = link.addr[9:0];
            next_st.accData = link.dqLevel;
            next_st.accMask = link.dqm;
            next_st.beat = 10'h001;
            next_st.active = next_st.mask != 10'h000;
            if (next_st.mask == 10'h000 && next_st.autoPre)
            begin
               next_st.bankOpen[link.ba] = 1'b0;
               next_st.autoPrePulse = 1'b1;
            end
         end
         CMD_TERMINATE:
         begin
            next_st.active = 1'b0;
            next_st.accValid = 1'b0;
         end
         CMD_PRECHARGE:
         begin
            if (link.addr[`PRECHARGE_SELECT_LINE])
            begin
               next_st.bankOpen = 4'h0;
            end
            else
            begin
               next_st.bankOpen[link.ba] = 1'b0;
            end
         end
         CMD_REFRESH: next_st.refreshPulse = 1'b1;
         CMD_SELF_REFRESH: next_st.selfRefresh = 1'b1;
         CMD_LOAD_MODE: next_st.mode = link.addr[11:0];
         default: ;
      endcase
      if (st.active && cmd != CMD_READ && cmd != CMD_WRITE)
      begin
         next_st.accBank = st.burstBank;
         next_st.accRow = st.openRow[st.burstBank];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st <= '0;
         st.mode <= `MR_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign link.dqMem = st.dqOut;
   assign link.dqMemOe = st.dqOe;
   assign accValid = st.accValid;
   assign accWrite = st.accWrite;
   assign accBank = st.accBank;
   assign accRow = st.accRow;
   assign accCol = st.accCol;
   assign accData = st.accData;
   assign accMask = st.accMask;
   assign bankOpen = st.bankOpen;
   assign modeConfig = st.mode;
   assign refreshPulse = st.refreshPulse;
   assign selfRefresh = st.selfRefresh;
   assign autoPrePulse = st.autoPrePulse;
endmodule

// ===== sdram_mode_and_command_decode_tb.sv
// Self-checking bench joining the controller end and the device end
`timescale 1ns/1ps
module sdram_mode_and_command_decode_tb;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] regAddr = 2'h0;
   logic [31:0] regWrData = 32'h0000_0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] regRdData;
   logic [15:0] readData = 16'h5a3c;
   logic accValid, accWrite, refreshPulse, selfRefresh, autoPrePulse, srSeen;
   logic [1:0] accBank, accMask;
   logic [12:0] accRow, lastRow;
   logic [9:0] accCol;
   logic [15:0] accData, lastData;
   logic [3:0] bankOpen;
   logic [11:0] modeConfig;
   logic [14:0] beats[$];
   int nRefresh = 0;
   int nAutoPre = 0;
   int cycles = 0;
   int n_errors = 0;
   int n_checks = 0;

   always #2.5 ref_clk = ~ref_clk;

   sdram_link_if link (.ref_clk(ref_clk));
   sdram_ctrl_end u_sdram_ctrl_end (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.ctrl), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
   sdram_mem_end u_sdram_mem_end (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.mem), .readData(readData),
      .accValid(accValid), .accWrite(accWrite), .accBank(accBank), .accRow(accRow), .accCol(accCol),
      .accData(accData), .accMask(accMask), .bankOpen(bankOpen), .modeConfig(modeConfig),
      .refreshPulse(refreshPulse), .selfRefresh(selfRefresh), .autoPrePulse(autoPrePulse));
   sdram_link_sva u_sdram_link_sva (.ref_clk(ref_clk), .reset_n(reset_n), .csN(link.csN), .rasN(link.rasN),
      .casN(link.casN), .weN(link.weN), .cke(link.cke), .addr(link.addr), .dqm(link.dqm),
      .dqCtrlOe(link.dqCtrlOe), .dqMemOe(link.dqMemOe));

   // ---------------------------------------------
   // Monitor and shared tasks
   // ---------------------------------------------
   always @(posedge ref_clk)
   begin
      cycles++;
      if (accValid === 1'b1)
      begin
         beats.push_back({accWrite, accBank, accMask, accCol});
         lastData = accData;
         lastRow = accRow;
      end
      nRefresh += int'(refreshPulse === 1'b1);
      nAutoPre += int'(autoPrePulse === 1'b1);
      srSeen = srSeen | (selfRefresh === 1'b1);
      if (cycles == 5000)
      begin
         n_errors++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic issue(input logic [3:0] c, input logic [14:0] a);
      wr(2'h0, {17'h0, a});
      wr(2'h2, {28'h0, c});
      // Third edge lets the monitor count pulses before any caller compares them
      repeat (3) @(posedge ref_clk);
   endtask

   function automatic logic [9:0] exp_col(input logic [11:0] m, input logic w, input logic [9:0] s, input int k);
      logic [9:0] msk;
      logic seq;
      msk = m[2:0] == 3'h7 ? 10'h3ff : (10'h1 << m[2:0]) - 10'h1;
      if (w && m[9])
         msk = 10'h0;
      seq = !m[3] || m[2:0] == 3'h7;
      return (s & ~msk) | ((seq ? s + 10'(k) : s ^ 10'(k)) & msk);
   endfunction

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic run_burst(input logic [11:0] m, input logic w, input logic [9:0] s, input logic [1:0] msk);
      logic [31:0] v;
      int len;
      int pre0;
      len = m[2:0] == 3'h7 ? 0 : (w && m[9]) ? 1 : 1 << m[2:0];
      issue(4'h6, 15'h0400);
      issue(4'h9, {3'h0, m});
      issue(4'h2, {2'h2, 13'h1abc});
      check("mode", modeConfig, m);
      wr(2'h1, {14'h0, msk, 16'hc3a5});
      check("open", bankOpen, 4'h4);
      beats.delete();
      pre0 = nAutoPre;
      // Writes ask for auto precharge, reads keep the row open
      wr(2'h0, {17'h0, 2'h2, 2'h0, w, s});
      wr(2'h2, {28'h0, w ? 4'h4 : 4'h3});
      if (len == 0)
         wr(2'h2, 32'h0000_0005);
      repeat (24) @(posedge ref_clk);
      if (len == 0)
         check("page count", beats.size() inside {[2:4]}, 1);
      else
         check("count", beats.size(), len);
      foreach (beats[k])
      begin
         check("col", beats[k][9:0], exp_col(m, w, s, k));
         check("bank", beats[k][14:12], {w, 2'h2});
         if (w)
            check("mask", beats[k][11:10], msk);
      end
      check("row", lastRow, 13'h1abc);
      check("auto pre", nAutoPre - pre0, w);
      check("after", bankOpen, w ? 4'h0 : 4'h4);
      if (w)
         check("wdata", lastData, 16'hc3a5);
      else
      begin
         rd(2'h3, v);
         check("fresh", v[16], msk != 2'b11);
         if (msk != 2'b11)
            check("rdata", v[15:0], readData);
      end
      $display("burst mode %h write %b done", m, w);
   endtask

   task automatic t_banks();
      logic [31:0] v;
      issue(4'h6, 15'h0400);
      issue(4'h2, {2'h0, 13'h0011});
      issue(4'h2, {2'h3, 13'h0022});
      issue(4'h9, 15'h0022);
      rd(2'h2, v);
      check("refused", v[5:0], 6'h19);
      check("kept", modeConfig, 12'h027);
      issue(4'h6, {2'h3, 13'h0000});
      check("one bank", bankOpen, 4'h1);
      issue(4'h6, {2'h2, 13'h0400});
      check("all banks", bankOpen, 4'h0);
      issue(4'h9, 15'h0025);
      check("reserved", modeConfig, 12'h027);
      $display("bank and refusal test done");
   endtask

   task automatic t_refresh();
      srSeen = 1'b0;
      issue(4'h7, 15'h0000);
      check("auto refresh", nRefresh, 1);
      check("no self", srSeen, 1'b0);
      issue(4'h8, 15'h0000);
      check("self refresh", srSeen, 1'b1);
      $display("refresh test done");
   endtask

   initial
   begin
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      #1;
      check("reset mode", modeConfig, 12'h000);
      check("reset banks", bankOpen, 4'h0);
      run_burst(12'h020, 1'b0, 10'h3ff, 2'b00);
      run_burst(12'h028, 1'b0, 10'h3ff, 2'b00);
      run_burst(12'h021, 1'b1, 10'h2d5, 2'b01);
      run_burst(12'h029, 1'b0, 10'h2d5, 2'b00);
      run_burst(12'h022, 1'b0, 10'h3f5, 2'b00);
      run_burst(12'h032, 1'b0, 10'h2d6, 2'b00);
      run_burst(12'h02a, 1'b1, 10'h2d5, 2'b10);
      run_burst(12'h023, 1'b0, 10'h2d5, 2'b11);
      run_burst(12'h02b, 1'b1, 10'h2d5, 2'b00);
      run_burst(12'h22b, 1'b1, 10'h2d5, 2'b00);
      run_burst(12'h22b, 1'b0, 10'h2d5, 2'b00);
      run_burst(12'h027, 1'b0, 10'h3ff, 2'b00);
      t_banks();
      t_refresh();
      close_out();
   end
endmodule
